// ### core/dirr_pkg.sv
// Constants shared by the indirect register read block
package dirr_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_REQ     = 8'h00;  // indirect_read_request
  localparam logic [7:0] OFS_VALUE   = 8'h04;  // indirect_read_value
  localparam logic [7:0] OFS_INT_STS = 8'h08;  // interrupt_status_register
  localparam logic [7:0] OFS_INT_CLR = 8'h0C;  // Write-one-to-clear
  localparam logic [7:0] OFS_INT_EN  = 8'h10;  // Interrupt enable

  // ---------------------------------------------------------------
  // Request register fields
  // ---------------------------------------------------------------
  localparam int         REQ_BIT     = 31;
  localparam int         ABORT_BIT   = 30;
  localparam int         ADR_MSB     = 7;
  localparam int         ADR_LSB     = 2;
  localparam int         ADR_W       = 6;
  localparam int         TGT_AW      = 8;      // Byte address toward the controller

  // ---------------------------------------------------------------
  // Interrupt status fields
  // ---------------------------------------------------------------
  localparam int         IRQ_W       = 2;
  localparam int         STS_RD_DONE = 0;      // Indirect read finished
  localparam int         STS_ABORTED = 1;      // Forced cancellation finished

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0]     RST_WORD = 32'h0000_0000;
  localparam logic [ADR_W-1:0] RST_ADR = 6'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

  // ---------------------------------------------------------------
  // Target registers software may select (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [TGT_AW-1:0] TGT_MW_CUR_ADR  = 8'h48;  // master_write_current_address
  localparam logic [TGT_AW-1:0] TGT_MR_CUR_ADR  = 8'h58;  // master_read_current_address
  localparam logic [TGT_AW-1:0] TGT_TIMEOUT_CNT = 8'h88;  // timeout_counter

  // Fetch engine states
  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b00,
    FETCH_WAIT = 2'b01,
    FETCH_DONE = 2'b10
  } dirr_fetch_state_t;

endpackage : dirr_pkg

// ### core/dirr_fetch_if.sv
// Link between the register bank and the fetch engine
`timescale 1ns/10ps
`default_nettype none

interface dirr_fetch_if;
  logic                        go;       // Request bit level
  logic                        abort;    // Abort bit level
  logic [dirr_pkg::ADR_W-1:0]  adr;      // Word address field
  logic                        busy;     // Engine not idle
  logic                        done;     // One-cycle completion pulse
  logic [31:0]                 data;     // Fetched word, valid with done

  modport bank   (output go, output abort, output adr, input busy, input done, input data);
  modport engine (input go, input abort, input adr, output busy, output done, output data);
endinterface : dirr_fetch_if

`default_nettype wire

// ### core/dirr_fetch.sv
// Fetch engine that reads one internal controller register
`timescale 1ns/10ps
`default_nettype none

module dirr_fetch (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  dirr_fetch_if.engine                         fi,
  output var  logic                            ctl_rd_req,
  output var  logic [dirr_pkg::TGT_AW-1:0]     ctl_rd_addr,
  input  wire logic                            ctl_rd_ack,
  input  wire logic [31:0]                     ctl_rd_data
);

  dirr_pkg::dirr_fetch_state_t state_r;
  logic                        done_r;
  logic [31:0]                 data_r;

  assign fi.busy = (state_r != dirr_pkg::FETCH_IDLE);
  assign fi.done = done_r;
  assign fi.data = data_r;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------

  // Abort beats everything; a completed word is handed over once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= dirr_pkg::FETCH_IDLE;
      ctl_rd_req  <= 1'b0;
      ctl_rd_addr <= '0;
      done_r      <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        dirr_pkg::FETCH_IDLE: begin
          if (fi.go && !fi.abort) begin
            ctl_rd_req  <= 1'b1;
            ctl_rd_addr <= {fi.adr, 2'b00};
            state_r     <= dirr_pkg::FETCH_WAIT;
          end
        end
        dirr_pkg::FETCH_WAIT: begin
          if (fi.abort) begin
            ctl_rd_req <= 1'b0;
            state_r    <= dirr_pkg::FETCH_IDLE;
          end else if (ctl_rd_ack) begin
            ctl_rd_req <= 1'b0;
            done_r     <= 1'b1;
            state_r    <= dirr_pkg::FETCH_DONE;
          end
        end
        dirr_pkg::FETCH_DONE: begin
          state_r <= dirr_pkg::FETCH_IDLE;                // Bank drops go meanwhile
        end
        default: begin
          state_r    <= dirr_pkg::FETCH_IDLE;
          ctl_rd_req <= 1'b0;
        end
      endcase
    end
  end

  // Capture the returned word beside the acknowledge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= dirr_pkg::RST_WORD;
    end else if (state_r == dirr_pkg::FETCH_WAIT && ctl_rd_ack && !fi.abort) begin
      data_r <= ctl_rd_data;
    end
  end

endmodule : dirr_fetch

`default_nettype wire

// ### core/dirr_top.sv
// Register bank of the indirect controller register read port
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module dirr_top #(
  parameter int BUS_AW = 8
) (
  input  wire logic                         core_clk,
  input  wire logic                         arst_n,
  input  wire logic [BUS_AW-1:0]            bus_addr,
  input  wire logic [31:0]                  bus_wdata,
  input  wire logic                         bus_wr,
  input  wire logic                         bus_rd,
  output var  logic [31:0]                  bus_rdata,
  output var  logic                         irq,
  output var  logic                         ctl_rd_req,
  output var  logic [dirr_pkg::TGT_AW-1:0]  ctl_rd_addr,
  input  wire logic                         ctl_rd_ack,
  input  wire logic [31:0]                  ctl_rd_data
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------

  // The map needs at least five address bits to reach every register
  if (BUS_AW < 5 || BUS_AW > 8) begin : g_bad_aw
    $error("dirr_top: BUS_AW must lie between 5 and 8");
  end

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  // Assert at once, release through two flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic                          req_r;
  logic                          abort_r;
  logic [dirr_pkg::ADR_W-1:0]    adr_r;
  logic [31:0]                   value_r;
  logic [dirr_pkg::IRQ_W-1:0]    sts_r;
  logic [dirr_pkg::IRQ_W-1:0]    en_r;
  logic [dirr_pkg::IRQ_W-1:0]    sts_set;
  logic [dirr_pkg::IRQ_W-1:0]    sts_clr;
  logic [7:0]                    addr8;
  logic                          wr_req;
  logic                          wr_clr;
  logic                          wr_en;
  logic                          start_wr;
  logic                          abort_wr;
  logic                          abort_end;

  dirr_fetch_if fi ();

  // Decode against a full byte address
  assign addr8    = 8'(bus_addr);
  assign wr_req   = bus_wr && (addr8 == dirr_pkg::OFS_REQ);
  assign wr_clr   = bus_wr && (addr8 == dirr_pkg::OFS_INT_CLR);
  assign wr_en    = bus_wr && (addr8 == dirr_pkg::OFS_INT_EN);
  assign abort_wr = wr_req && bus_wdata[dirr_pkg::ABORT_BIT];
  assign start_wr = wr_req && bus_wdata[dirr_pkg::REQ_BIT] && !abort_wr;

  // Abort is over once the engine has fallen back to idle
  assign abort_end = abort_r && !fi.busy;

  // Hand the bank state to the engine
  assign fi.go    = req_r;
  assign fi.abort = abort_r;
  assign fi.adr   = adr_r;

  // ---------------------------------------------------------------
  // Request register
  // ---------------------------------------------------------------

  // Request bit: set by software, cleared by completion or abort
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      req_r <= 1'b0;
    end else if (abort_wr || abort_r) begin
      req_r <= 1'b0;
    end else if (fi.done) begin
      req_r <= 1'b0;
    end else if (start_wr) begin
      req_r <= 1'b1;
    end
  end

  // Abort bit: held until the engine is idle, then self-clears
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      abort_r <= 1'b0;
    end else if (abort_wr) begin
      abort_r <= 1'b1;
    end else if (abort_end) begin
      abort_r <= 1'b0;
    end
  end

  // Address field; other bits of the word are dropped
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      adr_r <= dirr_pkg::RST_ADR;
    end else if (wr_req && !req_r) begin
      adr_r <= bus_wdata[dirr_pkg::ADR_MSB:dirr_pkg::ADR_LSB];
    end
  end

  // ---------------------------------------------------------------
  // Value register
  // ---------------------------------------------------------------

  // Loaded only by a completed fetch, never by the bus
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      value_r <= dirr_pkg::RST_WORD;
    end else if (fi.done && !abort_r) begin
      value_r <= fi.data;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, clear and enable
  // ---------------------------------------------------------------
  assign sts_set[dirr_pkg::STS_RD_DONE] = fi.done && !abort_r;
  assign sts_set[dirr_pkg::STS_ABORTED] = abort_end;
  assign sts_clr = wr_clr ? bus_wdata[dirr_pkg::IRQ_W-1:0] : dirr_pkg::RST_IRQ;

  // Sticky flags; a set in the clearing cycle wins
  generate
    for (genvar i = 0; i < dirr_pkg::IRQ_W; i++) begin : g_sts
      always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          sts_r[i] <= 1'b0;
        end else if (sts_set[i]) begin
          sts_r[i] <= 1'b1;
        end else if (sts_clr[i]) begin
          sts_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Enable mask
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      en_r <= dirr_pkg::RST_IRQ;
    end else if (wr_en) begin
      en_r <= bus_wdata[dirr_pkg::IRQ_W-1:0];
    end
  end

  // Level interrupt, one cycle behind the flags
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sts_r & en_r);
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------

  // Read data stand for one cycle after the strobe; else zero
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bus_rdata <= dirr_pkg::RST_WORD;
    end else if (bus_rd) begin
      unique case (addr8)
        dirr_pkg::OFS_REQ: begin
          bus_rdata <= {req_r, abort_r, 22'h00_0000, adr_r, 2'b00};
        end
        dirr_pkg::OFS_VALUE: begin
          bus_rdata <= value_r;
        end
        dirr_pkg::OFS_INT_STS: begin
          bus_rdata <= {30'h0000_0000, sts_r};
        end
        dirr_pkg::OFS_INT_EN: begin
          bus_rdata <= {30'h0000_0000, en_r};
        end
        default: begin
          bus_rdata <= dirr_pkg::RST_WORD;                // Unmapped and write-only
        end
      endcase
    end else begin
      bus_rdata <= dirr_pkg::RST_WORD;
    end
  end

  // ---------------------------------------------------------------
  // Fetch engine
  // ---------------------------------------------------------------

  // Drives the controller read port straight from its flops
  dirr_fetch u_fetch (
    .clk         (core_clk),
    .rst_n       (rst_n_r),
    .fi          (fi.engine),
    .ctl_rd_req  (ctl_rd_req),
    .ctl_rd_addr (ctl_rd_addr),
    .ctl_rd_ack  (ctl_rd_ack),
    .ctl_rd_data (ctl_rd_data)
  );

endmodule : dirr_top

`default_nettype wire

// ### bench/dirr_top_checker.sv
// Port-level assertions for the indirect register read block
`timescale 1ns/10ps
`default_nettype none

module dirr_top_checker #(
  parameter int BUS_AW = 8
) (
  input  wire logic                         core_clk,
  input  wire logic                         arst_n,
  input  wire logic [BUS_AW-1:0]            bus_addr,
  input  wire logic [31:0]                  bus_wdata,
  input  wire logic                         bus_wr,
  input  wire logic                         bus_rd,
  input  wire logic [31:0]                  bus_rdata,
  input  wire logic                         irq,
  input  wire logic                         ctl_rd_req,
  input  wire logic [dirr_pkg::TGT_AW-1:0]  ctl_rd_addr,
  input  wire logic                         ctl_rd_ack,
  input  wire logic [31:0]                  ctl_rd_data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic       to_req;
  logic       wr_go;
  logic       wr_stop;
  logic       stop_r;
  logic [1:0] en_r;

  // Decode writes to the request register
  assign to_req  = bus_wr && (bus_addr == BUS_AW'(dirr_pkg::OFS_REQ));
  assign wr_stop = to_req && bus_wdata[dirr_pkg::ABORT_BIT];
  assign wr_go   = to_req && bus_wdata[dirr_pkg::REQ_BIT] && !wr_stop;

  // Mirror of the enable register and of an abort write one cycle back
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_r   <= 2'h0;
      stop_r <= 1'b0;
    end else begin
      stop_r <= wr_stop;
      if (bus_wr && bus_addr == BUS_AW'(dirr_pkg::OFS_INT_EN)) en_r <= bus_wdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_go;   wr_go && !ctl_rd_req; endsequence
  sequence s_fill; ctl_rd_req && ctl_rd_ack && !wr_stop && !stop_r; endsequence

  a_start_fetch: assert property (s_go |-> ##2 ctl_rd_req &&
    ctl_rd_addr == {$past(bus_wdata[7:2], 2), 2'b00}) else $error("fetch not started");
  a_req_holds: assert property (ctl_rd_req && !ctl_rd_ack && !wr_stop && !stop_r
    |=> ctl_rd_req && $stable(ctl_rd_addr)) else $error("fetch request dropped");
  a_ack_ends: assert property (ctl_rd_req && ctl_rd_ack |=> !ctl_rd_req)
    else $error("fetch request held after answer");
  a_done_irq: assert property (s_fill ##0 en_r[0] |-> ##3 irq)
    else $error("no read-done interrupt");
  a_abort_drop: assert property (wr_stop |-> ##2 !ctl_rd_req [*2])
    else $error("abort left request up");
  a_abort_done: assert property (wr_stop && en_r[1] |-> ##[3:4] irq)
    else $error("abort never finished");
  a_irq_cause: assert property (irq |-> $past(en_r) != 2'h0)
    else $error("interrupt without enable");
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data outside read slot");
  a_req_spare: assert property (bus_rd && bus_addr == BUS_AW'(dirr_pkg::OFS_REQ)
    |=> (bus_rdata & 32'h3FFF_FF03) == 32'h0) else $error("spare bits not zero");
  a_req_busy: assert property (bus_rd && bus_addr == BUS_AW'(dirr_pkg::OFS_REQ)
    && ctl_rd_req && !wr_stop && !stop_r |=> bus_rdata[31]) else $error("request bit low early");
endmodule : dirr_top_checker

bind dirr_top dirr_top_checker #(.BUS_AW(BUS_AW)) u_checker (.core_clk(core_clk), .arst_n(arst_n),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .irq(irq), .ctl_rd_req(ctl_rd_req), .ctl_rd_addr(ctl_rd_addr), .ctl_rd_ack(ctl_rd_ack),
  .ctl_rd_data(ctl_rd_data));

`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the indirect register read block
`timescale 1ns/10ps
`default_nettype none

module testbench;
  typedef struct packed { logic [7:0] tgt; logic [31:0] word; } dirr_row_t;

  logic        core_clk    = 1'b0;
  logic        arst_n      = 1'b0;
  logic [7:0]  bus_addr    = 8'h00;
  logic [31:0] bus_wdata   = 32'h0;
  logic        bus_wr      = 1'b0;
  logic        bus_rd      = 1'b0;
  logic        ctl_rd_ack  = 1'b0;
  logic [31:0] ctl_rd_data = 32'h0;
  logic [31:0] bus_rdata;
  logic        irq;
  logic        ctl_rd_req;
  logic [7:0]  ctl_rd_addr;
  int          errors      = 0;
  int          compares    = 0;
  dirr_row_t   rows [3]    = '{'{8'h48, 32'hA5C3_0F18}, '{8'h58, 32'hFFFF_FFFF}, '{8'h88, 32'h0000_0001}};
  logic [7:0]  ofs [6]     = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};

  dirr_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq), .ctl_rd_req(ctl_rd_req),
    .ctl_rd_addr(ctl_rd_addr), .ctl_rd_ack(ctl_rd_ack), .ctl_rd_data(ctl_rd_data));

  // Clock of 10 ns period
  always #5 core_clk = ~core_clk;

  // ---------------------------------------------------------------
  // Bus and controller tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge core_clk);
    bus_wr    <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd   <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask : rd_chk

  // Wait for the fetch request, check its target, then answer it
  task automatic fetch(input logic [7:0] a, input logic [31:0] d);
    for (int i = 0; i < 20 && ctl_rd_req !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk({23'h0, ctl_rd_req, ctl_rd_addr}, {23'h0, 1'b1, a});
    @(posedge core_clk);
    ctl_rd_ack  <= 1'b1;
    ctl_rd_data <= d;
    @(posedge core_clk);
    ctl_rd_ack  <= 1'b0;
    ctl_rd_data <= ~d; // Stale data is never left on the lines
  endtask : fetch

  task automatic rst();
    arst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : rst

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // Watchdog against a hung handshake
  initial begin
    #20000;
    errors++;
    test_done();
  end

  // Main sequence
  initial begin
    rst();
    wr(dirr_pkg::OFS_INT_EN, 32'h3);
    foreach (rows[i]) begin
      wr(dirr_pkg::OFS_REQ, {24'h80_0000, rows[i].tgt});
      rd_chk(dirr_pkg::OFS_REQ, {24'h80_0000, rows[i].tgt});
      fetch(rows[i].tgt, rows[i].word);
      rd_chk(dirr_pkg::OFS_INT_STS, 32'h1);
      rd_chk(dirr_pkg::OFS_REQ, {24'h0, rows[i].tgt});
      rd_chk(dirr_pkg::OFS_VALUE, rows[i].word);
      chk({31'h0, irq}, 32'h1);
      wr(dirr_pkg::OFS_INT_CLR, 32'h1);
      rd_chk(dirr_pkg::OFS_INT_STS, 32'h0);
    end
    // Spare bits and read-only registers
    wr(dirr_pkg::OFS_REQ, 32'h3FFF_FFFF);
    rd_chk(dirr_pkg::OFS_REQ, 32'h0000_00FC);
    wr(dirr_pkg::OFS_VALUE, 32'h0F0F_0F0F);
    wr(dirr_pkg::OFS_INT_STS, 32'h3);
    rd_chk(dirr_pkg::OFS_VALUE, rows[2].word);
    rd_chk(dirr_pkg::OFS_INT_STS, 32'h0);
    // Abort while the fetch waits, with interrupts masked
    wr(dirr_pkg::OFS_INT_EN, 32'h0);
    wr(dirr_pkg::OFS_REQ, 32'h8000_0058);
    repeat (3) @(posedge core_clk);
    wr(dirr_pkg::OFS_REQ, 32'h4000_0000);
    repeat (2) @(posedge core_clk);
    #1;
    chk({31'h0, ctl_rd_req}, 32'h0);
    @(posedge core_clk);
    ctl_rd_ack  <= 1'b1;
    ctl_rd_data <= 32'h0BAD_F00D;
    @(posedge core_clk);
    ctl_rd_ack  <= 1'b0;
    rd_chk(dirr_pkg::OFS_REQ, 32'h0000_0058);
    rd_chk(dirr_pkg::OFS_INT_STS, 32'h2);
    rd_chk(dirr_pkg::OFS_VALUE, rows[2].word);
    chk({31'h0, irq}, 32'h0);
    wr(dirr_pkg::OFS_INT_EN, 32'h2);
    @(posedge core_clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr(dirr_pkg::OFS_INT_CLR, 32'h3);
    @(posedge core_clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    // Request and abort together while idle
    wr(dirr_pkg::OFS_REQ, 32'hC000_0088);
    repeat (3) @(posedge core_clk);
    #1;
    chk({31'h0, ctl_rd_req}, 32'h0);
    rd_chk(dirr_pkg::OFS_REQ, 32'h0000_0088);
    rd_chk(dirr_pkg::OFS_INT_STS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    // Reset in mid-run returns every register to zero
    rst();
    foreach (ofs[i]) rd_chk(ofs[i], 32'h0);
    chk({31'h0, irq}, 32'h0);
    test_done();
  end
endmodule : testbench

`default_nettype wire
